// File: fcse_pkg.sv
// Contract
// - Host judges completion by bit 7, errors 5-3
// - Byte write is 40h then data cycle
// - Odd status on bits 15:8, even 7:0
// - Strobe or select high between status reads
// - Host never clears status while suspended
// - Host masks reserved status bits 2 to 0
// - Host may batch operations, then check once
// - Erase is 20h then D0h; B0h suspends/resumes
`default_nettype none
package fcse_pkg;
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 4;
  // Bus timing at a 20 ns clock
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned T_ADDR_SETUP_NS = 20;
  localparam int unsigned T_WRITE_PULSE_NS = 120;
  localparam int unsigned T_READ_ACCESS_NS = 200;
  localparam int unsigned T_HOLD_NS = 30;
  localparam int unsigned SYNC_CYC = 2;
  localparam int unsigned SETUP_CYC = (T_ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE_CYC = (T_WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_CYC = (T_READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int unsigned HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // Command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_SUSPEND_RESUME = 8'hb0;
  // Status bit positions within one byte lane
  localparam int unsigned SR_READY = 7;
  localparam int unsigned SR_SUSPENDED = 6;
  localparam int unsigned SR_ERASE_ERR = 5;
  localparam int unsigned SR_PROG_ERR = 4;
  localparam int unsigned SR_SUPPLY_LOW = 3;
  localparam logic [7:0] SR_KEEP_MASK = 8'hf8;
  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;

  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_ARRAY_MODE = 3'b001,
    OP_STATUS = 3'b010,
    OP_CLEAR = 3'b011,
    OP_ERASE = 3'b100,
    OP_WRITE = 3'b101,
    OP_SUSPEND = 3'b110,
    OP_RESUME = 3'b111
  } fcse_op_t;

  typedef struct packed {
    fcse_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic word;
    logic poll;
  } fcse_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_o;
    logic data_oe;
    logic write_strobe_n;
    logic read_strobe_n;
    logic even_byte_select_n;
    logic odd_byte_select_n;
  } fcse_pins_t;

  localparam fcse_pins_t PINS_IDLE = '{addr: '0, data_o: '0, data_oe: 1'b0,
    write_strobe_n: 1'b1, read_strobe_n: 1'b1, even_byte_select_n: 1'b1,
    odd_byte_select_n: 1'b1};
endpackage : fcse_pkg
`default_nettype wire

// File: fcse_bus.sv
`default_nettype none
module fcse_bus
  import fcse_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_read,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [1:0] lanes,
  input wire logic [DATA_W-1:0] data_i,
  output var fcse_pins_t pins,
  output logic [DATA_W-1:0] rdata,
  output logic done
);
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_STROBE = 2'b10,
    PH_HOLD = 2'b11
  } fcse_phase_t;

  typedef struct packed {
    fcse_phase_t ph;
    logic [CNT_W-1:0] cnt;
    logic rd;
    fcse_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic done;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
  } fcse_bus_state_t;

  fcse_bus_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.sync1 = data_i;
    s_d.sync2 = s_q.sync1;
    unique case (s_q.ph)
      PH_IDLE: begin
        s_d.pins = PINS_IDLE;
        if (start) begin
          s_d.rd = is_read;
          s_d.pins.addr = addr;
          s_d.pins.data_o = wdata;
          s_d.pins.data_oe = !is_read;
          s_d.pins.even_byte_select_n = !lanes[0];
          s_d.pins.odd_byte_select_n = !lanes[1];
          s_d.cnt = CNT_W'(SETUP_CYC - 1);
          s_d.ph = PH_SETUP;
        end
      end
      PH_SETUP: begin
        if (s_q.cnt == '0) begin
          s_d.pins.write_strobe_n = s_q.rd;
          s_d.pins.read_strobe_n = !s_q.rd;
          s_d.cnt = s_q.rd ? CNT_W'(READ_CYC - 1) : CNT_W'(WRITE_CYC - 1);
          s_d.ph = PH_STROBE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      PH_STROBE: begin
        if (s_q.cnt == '0) begin
          if (s_q.rd) begin
            s_d.rdata = s_q.sync2;
          end
          s_d.pins.write_strobe_n = 1'b1;
          s_d.pins.read_strobe_n = 1'b1;
          s_d.cnt = CNT_W'(HOLD_CYC - 1);
          s_d.ph = PH_HOLD;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      PH_HOLD: begin
        if (s_q.cnt == '0) begin
          s_d.pins = PINS_IDLE;
          s_d.done = 1'b1;
          s_d.ph = PH_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{ph: PH_IDLE, cnt: '0, rd: 1'b0, pins: PINS_IDLE, rdata: '0,
        done: 1'b0, sync1: '0, sync2: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins = s_q.pins;
  assign rdata = s_q.rdata;
  assign done = s_q.done;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_write_pulse;
    $fell(pins.write_strobe_n) |-> (!pins.write_strobe_n)[*6] ##1 pins.write_strobe_n;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("Write strobe width wrong");

  property p_write_data_driven;
    !pins.write_strobe_n |-> pins.data_oe && pins.read_strobe_n && $stable(pins.data_o);
  endproperty
  a_write_data_driven: assert property (p_write_data_driven)
    else $error("Write data not held");

  property p_read_gap;
    done && s_q.rd |-> pins.read_strobe_n && pins.even_byte_select_n && pins.odd_byte_select_n;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("No strobe gap after status read");
endmodule : fcse_bus
`default_nettype wire

// File: fcse_host.sv
`default_nettype none
module fcse_host
  import fcse_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fcse_req_t req,
  output logic req_ready,
  output logic rsp_done,
  output logic rsp_refused,
  output logic rsp_ok,
  output logic [DATA_W-1:0] rsp_data,
  output logic [DATA_W-1:0] status_word,
  output logic erase_suspended,
  input wire logic [DATA_W-1:0] card_data_i,
  output var fcse_pins_t card_pins
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_W1 = 3'b001,
    ST_W2 = 3'b010,
    ST_SR_CMD = 3'b011,
    ST_SR_RD = 3'b100,
    ST_RD = 3'b101
  } fcse_step_t;

  typedef struct packed {
    fcse_step_t st;
    logic issued;
    fcse_req_t req;
    logic ready;
    logic done;
    logic refused;
    logic ok;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] status;
    logic susp;
  } fcse_host_state_t;

  fcse_host_state_t s_q, s_d;
  logic bus_start;
  logic bus_read;
  logic [DATA_W-1:0] bus_wdata;
  logic [DATA_W-1:0] bus_rdata;
  logic bus_done;
  logic [1:0] lanes;
  logic [DATA_W-1:0] sr_now;

  function automatic logic [1:0] lane_sel(input fcse_req_t r);
    return r.word ? 2'b11 : (r.addr[0] ? 2'b10 : 2'b01);
  endfunction : lane_sel

  function automatic logic [DATA_W-1:0] sr_masked(input logic [DATA_W-1:0] d,
                                                  input logic [1:0] l);
    return {d[15:8] & SR_KEEP_MASK & {8{l[1]}}, d[7:0] & SR_KEEP_MASK & {8{l[0]}}};
  endfunction : sr_masked

  function automatic logic sr_ready(input logic [DATA_W-1:0] d, input logic [1:0] l);
    return (d[SR_READY] | !l[0]) & (d[8 + SR_READY] | !l[1]);
  endfunction : sr_ready

  function automatic logic sr_error(input logic [DATA_W-1:0] d, input logic [1:0] l);
    return (l[0] & |d[SR_ERASE_ERR:SR_SUPPLY_LOW]) |
           (l[1] & |d[8 + SR_ERASE_ERR:8 + SR_SUPPLY_LOW]);
  endfunction : sr_error

  function automatic logic [7:0] first_code(input fcse_op_t op);
    unique case (op)
      OP_ARRAY_MODE: return CMD_READ_ARRAY;
      OP_CLEAR: return CMD_CLEAR_STATUS;
      OP_ERASE: return CMD_ERASE_SETUP;
      OP_WRITE: return CMD_WRITE_SETUP;
      OP_SUSPEND, OP_RESUME: return CMD_SUSPEND_RESUME;
      default: return CMD_READ_STATUS;
    endcase
  endfunction : first_code

  assign lanes = lane_sel(s_q.req);
  assign sr_now = sr_masked(bus_rdata, lanes);
  assign bus_start = (s_q.st != ST_IDLE) && !s_q.issued;
  assign bus_read = (s_q.st == ST_SR_RD) || (s_q.st == ST_RD);

  always_comb begin
    unique case (s_q.st)
      ST_W1: bus_wdata = {2{first_code(s_q.req.op)}};
      ST_W2: begin
        if (s_q.req.op == OP_ERASE) begin
          bus_wdata = {2{CMD_ERASE_CONFIRM}};
        end else begin
          bus_wdata = s_q.req.word ? s_q.req.data : {2{s_q.req.data[7:0]}};
        end
      end
      default: bus_wdata = {2{CMD_READ_STATUS}};
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.refused = 1'b0;
    if (bus_start) begin
      s_d.issued = 1'b1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (req_valid) begin
          s_d.req = req;
          s_d.ok = 1'b0;
          if (req.op == OP_CLEAR && s_q.susp) begin
            s_d.done = 1'b1;
            s_d.refused = 1'b1;
          end else begin
            s_d.ready = 1'b0;
            s_d.st = (req.op == OP_READ) ? ST_RD :
                     (req.op == OP_STATUS) ? ST_SR_CMD : ST_W1;
          end
        end
      end
      ST_W1: begin
        if (bus_done) begin
          s_d.issued = 1'b0;
          s_d.ok = 1'b1;
          if (s_q.req.op == OP_SUSPEND) begin
            s_d.susp = 1'b1;
          end
          if (s_q.req.op == OP_RESUME) begin
            s_d.susp = 1'b0;
          end
          if (s_q.req.op == OP_CLEAR) begin
            s_d.status = STATUS_RESET;
          end
          if (s_q.req.op == OP_ERASE || s_q.req.op == OP_WRITE) begin
            s_d.st = ST_W2;
          end else if (s_q.req.poll && (s_q.req.op == OP_SUSPEND || s_q.req.op == OP_RESUME)) begin
            s_d.st = ST_SR_CMD;
          end else begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_W2: begin
        if (bus_done) begin
          s_d.issued = 1'b0;
          s_d.ok = 1'b1;
          s_d.st = s_q.req.poll ? ST_SR_CMD : ST_IDLE;
        end
      end
      ST_SR_CMD: begin
        if (bus_done) begin
          s_d.issued = 1'b0;
          s_d.st = ST_SR_RD;
        end
      end
      ST_SR_RD: begin
        if (bus_done) begin
          s_d.issued = 1'b0;
          s_d.status = sr_now;
          s_d.susp = (lanes[0] & sr_now[SR_SUSPENDED]) |
                     (lanes[1] & sr_now[8 + SR_SUSPENDED]);
          s_d.ok = !sr_error(sr_now, lanes);
          if (s_q.req.op == OP_STATUS || sr_ready(sr_now, lanes)) begin
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_RD: begin
        if (bus_done) begin
          s_d.issued = 1'b0;
          s_d.ok = 1'b1;
          s_d.data = (!s_q.req.word && s_q.req.addr[0]) ? {8'h00, bus_rdata[15:8]} : bus_rdata;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (s_q.st != ST_IDLE && s_d.st == ST_IDLE) begin
      s_d.done = 1'b1;
      s_d.ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, issued: 1'b0, req: '0, ready: 1'b1, done: 1'b0,
        refused: 1'b0, ok: 1'b0, data: '0, status: STATUS_RESET, susp: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Repeated status reads reuse one 70h write; each read is its own strobe
  fcse_bus u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(bus_start),
    .is_read(bus_read),
    .addr(s_q.req.addr),
    .wdata(bus_wdata),
    .lanes(lanes),
    .data_i(card_data_i),
    .pins(card_pins),
    .rdata(bus_rdata),
    .done(bus_done)
  );

  assign req_ready = s_q.ready;
  assign rsp_done = s_q.done;
  assign rsp_refused = s_q.refused;
  assign rsp_ok = s_q.ok;
  assign rsp_data = s_q.data;
  assign status_word = s_q.status;
  assign erase_suspended = s_q.susp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_clear_refused;
    req_valid && req_ready && req.op == OP_CLEAR && erase_suspended
      |=> rsp_done && rsp_refused && $stable(card_pins);
  endproperty
  a_clear_refused: assert property (p_clear_refused)
    else $error("Clear sent while suspended");

  property p_busy_after_accept;
    req_valid && req_ready && !(req.op == OP_CLEAR && erase_suspended) |=> !req_ready;
  endproperty
  a_busy_after_accept: assert property (p_busy_after_accept)
    else $error("Ready during work");

  property p_poll_until_ready;
    rsp_done && !rsp_refused && s_q.req.poll &&
      (s_q.req.op == OP_ERASE || s_q.req.op == OP_WRITE) |-> sr_ready(status_word, lanes);
  endproperty
  a_poll_until_ready: assert property (p_poll_until_ready)
    else $error("Done before ready");

  property p_ok_from_errors;
    rsp_done && $past(s_q.st) == ST_SR_RD |-> rsp_ok == !sr_error(status_word, lanes);
  endproperty
  a_ok_from_errors: assert property (p_ok_from_errors) else $error("Error bits ignored");

  property p_reserved_masked;
    status_word[2:0] == 3'h0 && status_word[10:8] == 3'h0;
  endproperty
  a_reserved_masked: assert property (p_reserved_masked)
    else $error("Reserved bits kept");

  property p_erase_confirm;
    bus_start && s_q.st == ST_W2 && s_q.req.op == OP_ERASE
      |-> bus_wdata == {2{CMD_ERASE_CONFIRM}} && $past(s_q.st, 2) == ST_W1;
  endproperty
  a_erase_confirm: assert property (p_erase_confirm) else $error("Bad erase confirm");

  property p_write_setup;
    bus_start && s_q.st == ST_W1 && s_q.req.op == OP_WRITE |-> bus_wdata == {2{CMD_WRITE_SETUP}};
  endproperty
  a_write_setup: assert property (p_write_setup) else $error("Bad write setup code");

  property p_word_lanes;
    bus_start && s_q.req.word |=> !card_pins.even_byte_select_n && !card_pins.odd_byte_select_n;
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("Word access missed a lane");

  c_erase_polled: cover property (rsp_done && rsp_ok && s_q.req.op == OP_ERASE && s_q.req.poll);
  c_write_done: cover property (rsp_done && s_q.req.op == OP_WRITE);
  c_clear_refused: cover property (rsp_refused);
  c_status_read: cover property (rsp_done && s_q.req.op == OP_STATUS);
endmodule : fcse_host
`default_nettype wire

// File: fcse_card_model.sv
`default_nettype none
module fcse_card_model
  import fcse_pkg::*;
#(
  parameter int ERASE_CYC = 60,
  parameter int PROG_CYC = 10
) (
  input wire logic ref_clk,
  input wire fcse_pins_t card_pins,
  input wire logic supply_ok,
  output wire logic [DATA_W-1:0] card_data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [2][64];
  logic [2:0] err [2];
  logic [7:0] sr_lat [2];
  logic [7:0] pend [2];
  logic stat_mode [2];
  logic susp [2];
  logic resume_req [2];
  int ers_left [2];
  int prog_left [2];
  logic [5:0] ers_at [2];
  logic [5:0] prog_at [2];
  logic [7:0] prog_val [2];
  logic [1:0] sel_n;
  logic [7:0] d;
  assign sel_n = {card_pins.odd_byte_select_n, card_pins.even_byte_select_n};

  // Reserved bits read back nonzero so the host must mask them
  function automatic logic [7:0] status_of(int l);
    return {prog_left[l] == 0 && (ers_left[l] == 0 || susp[l]),
            susp[l], err[l], 3'b101};
  endfunction : status_of

  initial begin
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 64; i++) mem[l][i] = 8'(i * 3 + l + 1);
      err[l] = 3'b000;
      pend[l] = 8'h00;
      stat_mode[l] = 1'b0;
      susp[l] = 1'b0;
      resume_req[l] = 1'b0;
      ers_left[l] = 0;
      prog_left[l] = 0;
      sr_lat[l] = 8'h00;
    end
  end

  // Commands latch on the rising write strobe
  always @(posedge card_pins.write_strobe_n) begin
    for (int l = 0; l < 2; l++) begin
      if (!sel_n[l]) begin
        d = card_pins.data_o[l*8+:8];
        if (pend[l] == CMD_ERASE_SETUP) begin
          if (d != CMD_ERASE_CONFIRM) err[l] = err[l] | 3'b110;
          else if (!supply_ok) err[l][0] = 1'b1;
          else begin
            ers_left[l] = ERASE_CYC;
            ers_at[l] = card_pins.addr[6:1];
          end
          pend[l] = 8'h00;
        end else if (pend[l] == CMD_WRITE_SETUP) begin
          if (!supply_ok) err[l][0] = 1'b1;
          else begin
            prog_left[l] = PROG_CYC;
            prog_at[l] = card_pins.addr[6:1];
            prog_val[l] = d;
          end
          pend[l] = 8'h00;
        end else begin
          case (d)
            CMD_READ_ARRAY: stat_mode[l] = 1'b0;
            CMD_READ_STATUS: stat_mode[l] = 1'b1;
            CMD_CLEAR_STATUS: if (!susp[l]) err[l] = 3'b000;
            CMD_ERASE_SETUP, CMD_WRITE_SETUP: begin
              pend[l] = d;
              stat_mode[l] = 1'b1;
            end
            CMD_SUSPEND_RESUME: begin
              if (susp[l]) resume_req[l] = 1'b1;
              else if (ers_left[l] > 0) susp[l] = 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Engine runs whether or not the lane is selected
  always @(posedge ref_clk) begin
    for (int l = 0; l < 2; l++) begin
      if (prog_left[l] == 1) mem[l][prog_at[l]] = prog_val[l];
      if (prog_left[l] > 0) prog_left[l]--;
      if (ers_left[l] > 0 && !susp[l]) begin
        if (ers_left[l] == 1) begin
          for (int i = 0; i < 8; i++) mem[l][{ers_at[l][5:3], 3'(i)}] = 8'hff;
        end
        ers_left[l]--;
      end
      if (resume_req[l] && prog_left[l] == 0) begin
        susp[l] = 1'b0;
        resume_req[l] = 1'b0;
      end
    end
  end

  always @(negedge card_pins.read_strobe_n or negedge card_pins.even_byte_select_n
      or negedge card_pins.odd_byte_select_n) begin
    for (int l = 0; l < 2; l++) sr_lat[l] = status_of(l);
  end

  // Released lanes fall to the pull-down level
  for (genvar l = 0; l < 2; l++) begin : g_lane
    assign card_data_i[l*8+:8] = (!sel_n[l] && !card_pins.read_strobe_n) ?
        (stat_mode[l] ? sr_lat[l] : mem[l][card_pins.addr[6:1]]) : 8'h00;
  end
endmodule : fcse_card_model
`default_nettype wire

// File: fcse_host_tb.sv
`default_nettype none
module fcse_host_tb;
  import fcse_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  fcse_req_t req = '0;
  logic supply_ok = 1'b1;
  logic req_ready, rsp_done, rsp_refused, rsp_ok, erase_suspended, got_refused;
  logic [DATA_W-1:0] rsp_data, status_word, card_data;
  fcse_pins_t card_pins;
  int bad_count = 0;
  int checks = 0;

  always #10 ref_clk = ~ref_clk;

  fcse_host i_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_done(rsp_done), .rsp_refused(rsp_refused), .rsp_ok(rsp_ok),
    .rsp_data(rsp_data), .status_word(status_word), .erase_suspended(erase_suspended),
    .card_data_i(card_data), .card_pins(card_pins));
  fcse_card_model #(.ERASE_CYC(60), .PROG_CYC(10)) i_card (.ref_clk(ref_clk),
    .card_pins(card_pins), .supply_ok(supply_ok), .card_data_i(card_data));

  task automatic summarize;
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
      input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic issue(input fcse_op_t op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] dat, input logic w, input logic p);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{op: op, addr: a, data: dat, word: w, poll: p};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (rsp_done !== 1'b1 && n < 20000);
    got_refused = rsp_refused;
    if (n >= 20000) begin
      bad_count++;
      $display("BAD %0t no completion", $time);
      summarize();
    end
  endtask : issue

  task automatic t_reset;
    @(negedge ref_clk);
    chk({15'd0, req_ready}, 16'h0001, "ready idle");
    chk({14'd0, card_pins.even_byte_select_n, card_pins.odd_byte_select_n},
      16'h0003, "selects idle");
  endtask : t_reset

  task automatic t_array_read;
    issue(OP_READ, 26'h0000011, 16'h0000, 1'b0, 1'b0);
    chk(rsp_data, 16'h001a, "odd byte read");
    issue(OP_READ, 26'h0000004, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'h0807, "word read");
  endtask : t_array_read

  task automatic t_erase;
    issue(OP_ERASE, 26'h0000016, 16'h0000, 1'b1, 1'b1);
    chk(status_word, 16'h8080, "erase status");
    chk({15'd0, rsp_ok}, 16'h0001, "erase ok");
    issue(OP_ARRAY_MODE, 26'h0000000, 16'h0000, 1'b1, 1'b0);
    issue(OP_READ, 26'h0000010, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'hffff, "block start");
    issue(OP_READ, 26'h000001e, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'hffff, "block end");
    issue(OP_READ, 26'h0000020, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'h3231, "next block kept");
  endtask : t_erase

  task automatic t_write;
    issue(OP_WRITE, 26'h0000011, 16'h00c5, 1'b0, 1'b1);
    chk(status_word, 16'h8000, "odd lane status");
    issue(OP_ARRAY_MODE, 26'h0000000, 16'h0000, 1'b1, 1'b0);
    issue(OP_READ, 26'h0000010, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'hc5ff, "written byte");
  endtask : t_write

  task automatic t_suspend;
    issue(OP_ERASE, 26'h0000024, 16'h0000, 1'b1, 1'b0);
    issue(OP_SUSPEND, 26'h0000024, 16'h0000, 1'b1, 1'b1);
    chk(status_word, 16'hc0c0, "suspended status");
    chk({15'd0, erase_suspended}, 16'h0001, "suspend flag");
    issue(OP_CLEAR, 26'h0000000, 16'h0000, 1'b1, 1'b0);
    chk({15'd0, got_refused}, 16'h0001, "clear refused");
    issue(OP_WRITE, 26'h0000000, 16'h3c3c, 1'b1, 1'b1);
    chk(status_word, 16'hc0c0, "write in suspend");
    issue(OP_RESUME, 26'h0000024, 16'h0000, 1'b1, 1'b1);
    chk(status_word, 16'h8080, "resumed done");
    chk({15'd0, erase_suspended}, 16'h0000, "resume flag");
    issue(OP_ARRAY_MODE, 26'h0000000, 16'h0000, 1'b1, 1'b0);
    issue(OP_READ, 26'h0000024, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'hffff, "resumed erase");
    issue(OP_READ, 26'h0000000, 16'h0000, 1'b1, 1'b0);
    chk(rsp_data, 16'h3c3c, "other block write");
  endtask : t_suspend

  task automatic t_supply;
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    issue(OP_WRITE, 26'h0000002, 16'h0011, 1'b0, 1'b1);
    chk(status_word, 16'h0088, "supply low");
    chk({15'd0, rsp_ok}, 16'h0000, "supply error");
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    issue(OP_STATUS, 26'h0000002, 16'h0000, 1'b0, 1'b0);
    chk(status_word, 16'h0088, "error sticks");
    issue(OP_CLEAR, 26'h0000002, 16'h0000, 1'b0, 1'b0);
    issue(OP_STATUS, 26'h0000002, 16'h0000, 1'b0, 1'b0);
    chk(status_word, 16'h0080, "cleared");
    chk({15'd0, rsp_ok}, 16'h0001, "ok after clear");
  endtask : t_supply

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_array_read();
    t_erase();
    t_write();
    t_suspend();
    t_supply();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    summarize();
  end
endmodule : fcse_host_tb
`default_nettype wire
